// File: rtl/alm_defs.svh
// Register offsets, field positions and reset values of the alarm block
`ifndef ALM_DEFS_SVH
`define ALM_DEFS_SVH
`define ALM_IDX_SUMMARY 10'h2C0
`define ALM_IDX_STATUS 10'h2C1
`define ALM_IDX_MASK 10'h2C2
`define ALM_IDX_LANE 10'h2C4
`define ALM_IDX_CTRL 10'h2C8
`define ALM_IDX_IRQ_STAT 10'h2C9
`define ALM_IDX_IRQ_MASK 10'h2CA
`define ALM_BIT_FIFO 5
`define ALM_BIT_PLL 4
`define ALM_BIT_LINK 3
`define ALM_BIT_REALIGN 2
`define ALM_BIT_OSC 1
`define ALM_BIT_CLK 0
`define ALARM_MASK_RST 8'h3F
`define ALARM_STATUS_RST 6'h3F
`define ALM_LANE_RST 16'hFFFF
`define ALM_FLAG_MASK 8'h3F
`define ALM_IRQ_RST 2'h0
`define ALM_IRQ_FIFO 0
`define ALM_IRQ_LANE 1
`endif

// File: rtl/alm_pkg.sv
// Types shared by the alarm block
package alm_pkg;
  typedef logic [5:0] alm_flags_t;
  typedef logic [15:0] alm_lanes_t;
endpackage : alm_pkg

// File: rtl/alm_sticky.sv
// Sticky event bits with write-one-to-clear, set wins over clear
`timescale 1ns/1ns
module alm_sticky #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] q_reg;
  logic [WIDTH-1:0] q_next;
  initial begin
    if (WIDTH < 1) $error("WIDTH must be positive");
  end
  always_comb begin
    q_next = (q_reg & ~clr_i) | set_i;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_reg <= RST_VAL;
    end else begin
      q_reg <= q_next;
    end
  end
  assign q_o = q_reg;
endmodule : alm_sticky

// File: rtl/alm_top.sv
// Alarm mask, status, summary and per-lane FIFO alarm register bank
// Function
// - Mask bit 5 set keeps the FIFO flag out of the summary alarm.
// - Mask bit 4 set keeps the PLL lock-lost flag out of the summary alarm.
// - Mask bit 3 set keeps the link flag out of the summary alarm.
// - Mask bit 2 set keeps the realignment flag out of the summary alarm.
// - Mask bit 1 set keeps the oscillator phase flag out of the summary alarm.
// - Mask bit 0 set keeps the clock divider flag out of the summary alarm.
// - The mask resets to 0x3F with bits 7:6 reserved.
// - Lane i overflow or underflow sets lane alarm bit i.
// - Writing one to a lane alarm bit clears it; zeros leave bits alone.
// - A lane condition still present sets its bit again at once.
// - Writing one to the FIFO flag clears all lane alarm bits.
// - The lane alarm register resets to all ones.
// - The summary bit is one when any unmasked status flag is set.
// - Any lane FIFO error sets the FIFO flag; writing one clears it.
// - All status flags are one after power-on or soft reset.
// - A select bit drives the summary alarm onto the calibration status pin.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ns
`include "alm_defs.svh"
module alm_top #(
  parameter int LANES = 16
) (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic SOFT_RESET,
  input wire logic [31:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic WB_ACK_O,
  output logic WB_ERR_O,
  input wire alm_pkg::alm_lanes_t LANE_FIFO_ERR,
  input wire logic PLL_UNLOCKED,
  input wire logic LINK_DOWN,
  input wire logic CLK_REALIGNED,
  input wire logic OSC_UPSET,
  input wire logic CLK_DIV_MISMATCH,
  output logic CAL_STATUS_PIN,
  output logic IRQ
);
  import alm_pkg::*;

  initial begin
    if (LANES != 16) $error("LANES must be 16");
  end

  function automatic logic [9:0] word_idx(input logic [31:0] adr);
    word_idx = adr[11:2];
  endfunction : word_idx

  // Three-stage synchronisers for all asynchronous alarm sources
  localparam int NSRC = 22;
  logic [NSRC-1:0] src_raw;
  logic [NSRC-1:0] s1_reg;
  logic [NSRC-1:0] s2_reg;
  logic [NSRC-1:0] s3_reg;
  logic [NSRC-1:0] src_reg;
  logic [NSRC-1:0] src_next;
  assign src_raw = {CLK_DIV_MISMATCH, OSC_UPSET, CLK_REALIGNED, LINK_DOWN, PLL_UNLOCKED,
                    SOFT_RESET, LANE_FIFO_ERR};
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_sync
      assign src_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : src_reg[gi];
    end
  endgenerate
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      src_reg <= '0;
    end else begin
      s1_reg <= src_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      src_reg <= src_next;
    end
  end

  logic [15:0] lane_err;
  logic soft_rst;
  logic [5:0] cond;
  assign lane_err = src_reg[15:0];
  assign soft_rst = src_reg[16];
  assign cond = {|lane_err, src_reg[17], src_reg[18], src_reg[19], src_reg[20], src_reg[21]};

  // Bus decode
  logic req;
  logic wr;
  logic rd;
  logic [9:0] idx;
  logic hit;
  assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O;
  assign idx = word_idx(WB_ADR_I);
  always_comb begin
    if (idx == `ALM_IDX_SUMMARY) hit = 1'b1;
    else if (idx == `ALM_IDX_STATUS) hit = 1'b1;
    else if (idx == `ALM_IDX_MASK) hit = 1'b1;
    else if (idx == `ALM_IDX_LANE) hit = 1'b1;
    else if (idx == `ALM_IDX_CTRL) hit = 1'b1;
    else if (idx == `ALM_IDX_IRQ_STAT) hit = 1'b1;
    else if (idx == `ALM_IDX_IRQ_MASK) hit = 1'b1;
    else hit = 1'b0;
  end
  assign wr = req & hit & WB_WE_I;
  assign rd = req & hit & ~WB_WE_I;

  // Control registers
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic cal_sel_reg;
  logic cal_sel_next;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_mask_next;
  always_comb begin
    mask_next = mask_reg;
    cal_sel_next = cal_sel_reg;
    irq_mask_next = irq_mask_reg;
    if (soft_rst) begin
      mask_next = `ALARM_MASK_RST;
    end else if (wr && WB_SEL_I[0]) begin
      if (idx == `ALM_IDX_MASK) mask_next = WB_DAT_I[7:0];
      else if (idx == `ALM_IDX_CTRL) cal_sel_next = WB_DAT_I[0];
      else if (idx == `ALM_IDX_IRQ_MASK) irq_mask_next = WB_DAT_I[1:0];
    end
  end
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mask_reg <= `ALARM_MASK_RST;
      cal_sel_reg <= 1'b0;
      irq_mask_reg <= `ALM_IRQ_RST;
    end else begin
      mask_reg <= mask_next;
      cal_sel_reg <= cal_sel_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // Status flags and lane alarms: set beats clear
  logic stat_wr;
  logic lane_wr;
  logic [5:0] stat_clr;
  logic [5:0] stat_set;
  logic [15:0] lane_clr;
  logic [15:0] lane_set;
  alm_flags_t status;
  alm_lanes_t lanes;
  assign stat_wr = wr & WB_SEL_I[0] & (idx == `ALM_IDX_STATUS);
  assign lane_wr = wr & (idx == `ALM_IDX_LANE);
  assign stat_clr = stat_wr ? WB_DAT_I[5:0] : 6'h00;
  assign stat_set = soft_rst ? `ALARM_STATUS_RST : cond;
  assign lane_clr = (lane_wr ? (WB_DAT_I[15:0] & {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}})
                    : 16'h0000)
                  | {16{stat_clr[`ALM_BIT_FIFO]}};
  assign lane_set = soft_rst ? `ALM_LANE_RST : lane_err;

  alm_sticky #(.WIDTH(6), .RST_VAL(`ALARM_STATUS_RST)) u_status (
    .clk(MCLK), .arst_n(ARST_N), .set_i(stat_set), .clr_i(stat_clr), .q_o(status));
  alm_sticky #(.WIDTH(16), .RST_VAL(`ALM_LANE_RST)) u_lanes (
    .clk(MCLK), .arst_n(ARST_N), .set_i(lane_set), .clr_i(lane_clr), .q_o(lanes));

  // Summary alarm, registered each cycle
  logic summary_reg;
  logic summary_next;
  always_comb begin
    summary_next = |(status & ~mask_reg[5:0]);
  end

  // Interrupt: FIFO error level and summary alarm rising-edge events, cleared by reading
  logic [1:0] ev;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_stat_next;
  assign ev[`ALM_IRQ_FIFO] = cond[`ALM_BIT_FIFO];
  assign ev[`ALM_IRQ_LANE] = summary_next & ~summary_reg;
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (rd && idx == `ALM_IDX_IRQ_STAT) irq_stat_next = 2'h0;
    irq_stat_next = irq_stat_next | ev;
  end

  // Bus answer, one cycle after request
  logic ack_reg;
  logic err_reg;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  always_comb begin
    dat_next = dat_reg;
    if (rd) begin
      if (idx == `ALM_IDX_SUMMARY) dat_next = {31'h0, summary_reg};
      else if (idx == `ALM_IDX_STATUS) dat_next = {26'h0, status};
      else if (idx == `ALM_IDX_MASK) dat_next = {24'h0, mask_reg};
      else if (idx == `ALM_IDX_LANE) dat_next = {16'h0, lanes};
      else if (idx == `ALM_IDX_CTRL) dat_next = {31'h0, cal_sel_reg};
      else if (idx == `ALM_IDX_IRQ_STAT) dat_next = {30'h0, irq_stat_reg};
      else dat_next = {30'h0, irq_mask_reg};
    end
  end
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      summary_reg <= 1'b0;
      irq_stat_reg <= `ALM_IRQ_RST;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      summary_reg <= summary_next;
      irq_stat_reg <= irq_stat_next;
      ack_reg <= req & hit;
      err_reg <= req & ~hit;
      dat_reg <= dat_next;
    end
  end
  assign WB_ACK_O = ack_reg;
  assign WB_ERR_O = err_reg;
  assign WB_DAT_O = dat_reg;
  assign CAL_STATUS_PIN = cal_sel_reg & summary_reg;
  assign IRQ = |(irq_stat_reg & irq_mask_reg);

  // Checks
  a_summary_masked: assert property (@(posedge MCLK) disable iff (!ARST_N)
    summary_reg == $past(summary_next))
    else $error("summary alarm wrong");
  a_fifo_mask: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (mask_reg[5] && status[4:0] == 5'h0) |=> !summary_reg)
    else $error("masked fifo flag leaked");
  a_pll_mask: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (status == 6'h10 && !mask_reg[4]) |=> summary_reg)
    else $error("pll flag not reported");
  a_all_masked: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (mask_reg[5:0] == 6'h3F) |=> !summary_reg)
    else $error("all masked yet alarm");
  a_lane_set: assert property (@(posedge MCLK) disable iff (!ARST_N)
    lane_err[3] |=> lanes[3])
    else $error("lane alarm not set");
  a_lane_clear: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (lane_wr && WB_SEL_I[0] && WB_DAT_I[0] && !lane_err[0] && !soft_rst) |=> !lanes[0])
    else $error("lane alarm not cleared");
  a_global_clear: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (stat_clr[5] && lane_err == 16'h0 && !soft_rst) |=> lanes == 16'h0)
    else $error("global lane clear failed");
  a_fifo_flag: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (|lane_err) |=> status[5])
    else $error("fifo flag not set");
  a_soft_reset: assert property (@(posedge MCLK) disable iff (!ARST_N)
    soft_rst |=> (status == 6'h3F && lanes == 16'hFFFF && mask_reg == 8'h3F))
    else $error("soft reset values wrong");
  a_cal_pin: assert property (@(posedge MCLK) disable iff (!ARST_N)
    !cal_sel_reg |-> !CAL_STATUS_PIN)
    else $error("cal pin driven unselected");
endmodule : alm_top

// File: sim/alm_top_test.sv
// Self-checking bench for the alarm mask and lane alarm register bank
`timescale 1ns/1ns
`include "alm_defs.svh"
module alm_top_test;
  import alm_pkg::*;
  logic MCLK, ARST_N, SOFT_RESET, WB_WE_I, WB_CYC_I, WB_STB_I, WB_ACK_O, WB_ERR_O;
  logic [31:0] WB_ADR_I, WB_DAT_I, WB_DAT_O, rd;
  logic [3:0] WB_SEL_I;
  alm_lanes_t LANE_FIFO_ERR;
  logic [4:0] cond;
  logic CAL_STATUS_PIN, IRQ, err;
  int mismatches, check_count;

  alm_top i_alm_top (.MCLK(MCLK), .ARST_N(ARST_N), .SOFT_RESET(SOFT_RESET),
    .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_SEL_I(WB_SEL_I),
    .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
    .WB_ERR_O(WB_ERR_O), .LANE_FIFO_ERR(LANE_FIFO_ERR), .PLL_UNLOCKED(cond[4]),
    .LINK_DOWN(cond[3]), .CLK_REALIGNED(cond[2]), .OSC_UPSET(cond[1]),
    .CLK_DIV_MISMATCH(cond[0]), .CAL_STATUS_PIN(CAL_STATUS_PIN), .IRQ(IRQ));

  task automatic finish_test();
    if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
  endtask : cyc

  // Slave answer time is not assumed; a wait ends on ACK or ERR, or at the 50-cycle bound
  task automatic wb(input logic [9:0] idx, input logic we, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    WB_CYC_I <= 1'h1;
    WB_STB_I <= 1'h1;
    WB_ADR_I <= {20'h0, idx, 2'h0};
    WB_WE_I <= we;
    WB_DAT_I <= d;
    do begin
      @(posedge MCLK);
      n++;
    end while (WB_ACK_O !== 1'h1 && WB_ERR_O !== 1'h1 && n < 50);
    if (WB_ACK_O !== 1'h1 && WB_ERR_O !== 1'h1) begin
      mismatches++;
      $display("wrong value at %0t: bus hang", $time);
      finish_test();
    end
    rd = WB_DAT_O;
    err = WB_ERR_O;
    WB_CYC_I <= 1'h0;
    WB_STB_I <= 1'h0;
  endtask : wb

  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp, input string msg);
    wb(idx, 1'h0, 32'h0);
    chk(rd, exp, msg);
  endtask : rdchk

  initial begin
    MCLK = 1'h0;
    forever #10 MCLK = ~MCLK;
  end

  initial begin
    logic [7:0] m;
    alm_lanes_t r, w;
    {ARST_N, SOFT_RESET, WB_WE_I, WB_CYC_I, WB_STB_I} = 5'h0;
    {WB_ADR_I, WB_DAT_I} = 64'h0;
    WB_SEL_I = 4'hF;
    LANE_FIFO_ERR = 16'h0;
    cond = 5'h0;
    mismatches = 0;
    check_count = 0;
    void'($urandom(21));
    cyc(20);
    ARST_N <= 1'h1;
    rdchk(`ALM_IDX_MASK, 32'h3F, "mask reset");
    rdchk(`ALM_IDX_LANE, 32'hFFFF, "lane reset");
    rdchk(`ALM_IDX_STATUS, 32'h3F, "status reset");
    rdchk(`ALM_IDX_SUMMARY, 32'h0, "all masked");
    wb(10'h3FF, 1'h1, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped");
    wb(`ALM_IDX_CTRL, 1'h1, 32'h1);
    wb(`ALM_IDX_IRQ_MASK, 1'h1, 32'h2);
    for (int b = 0; b < 6; b++) begin
      cond <= 5'h0;
      LANE_FIFO_ERR <= 16'h0;
      wb(`ALM_IDX_MASK, 1'h1, 32'h3F);
      cyc(8);
      wb(`ALM_IDX_STATUS, 1'h1, 32'h3F);
      wb(`ALM_IDX_IRQ_STAT, 1'h0, 32'h0);
      if (b == 5) LANE_FIFO_ERR <= 16'h1 << $urandom_range(15);
      else cond[b] <= 1'h1;
      cyc(8);
      m = 8'($urandom);
      m[b] = 1'h1;
      wb(`ALM_IDX_MASK, 1'h1, {24'h0, m});
      cyc(3);
      rdchk(`ALM_IDX_SUMMARY, 32'h0, "masked flag");
      chk({31'h0, IRQ}, 32'h0, "irq idle");
      m[b] = 1'h0;
      wb(`ALM_IDX_MASK, 1'h1, {24'h0, m});
      rdchk(`ALM_IDX_MASK, {24'h0, m}, "mask rw");
      rdchk(`ALM_IDX_SUMMARY, 32'h1, "unmasked flag");
      chk({31'h0, CAL_STATUS_PIN}, 32'h1, "cal pin");
      chk({31'h0, IRQ}, 32'h1, "irq raised");
      wb(`ALM_IDX_IRQ_STAT, 1'h0, 32'h0);
      chk({31'h0, rd[1]}, 32'h1, "irq event");
      cyc(2);
      chk({31'h0, IRQ}, 32'h0, "irq cleared");
    end
    cond <= 5'h0;
    LANE_FIFO_ERR <= 16'h0;
    for (int i = 0; i < 4; i++) begin
      cyc(8);
      wb(`ALM_IDX_LANE, 1'h1, 32'hFFFF);
      wb(`ALM_IDX_STATUS, 1'h1, 32'h3F);
      rdchk(`ALM_IDX_LANE, 32'h0, "lane clear");
      r = (i == 0) ? 16'h8001 : 16'($urandom) | 16'h1;
      w = 16'($urandom);
      LANE_FIFO_ERR <= r;
      cyc(6);
      LANE_FIFO_ERR <= 16'h0;
      cyc(8);
      rdchk(`ALM_IDX_LANE, {16'h0, r}, "lane set");
      rdchk(`ALM_IDX_STATUS, 32'h20, "fifo flag");
      wb(`ALM_IDX_LANE, 1'h1, {16'h0, w});
      rdchk(`ALM_IDX_LANE, {16'h0, r & ~w}, "lane w1c");
      LANE_FIFO_ERR <= w;
      cyc(8);
      wb(`ALM_IDX_LANE, 1'h1, 32'hFFFF);
      rdchk(`ALM_IDX_LANE, {16'h0, w}, "lane persist");
      LANE_FIFO_ERR <= 16'h0;
      cyc(8);
      wb(`ALM_IDX_STATUS, 1'h1, 32'h20);
      rdchk(`ALM_IDX_LANE, 32'h0, "global clear");
      rdchk(`ALM_IDX_STATUS, 32'h0, "fifo flag w1c");
    end
    wb(`ALM_IDX_MASK, 1'h1, 32'h0);
    SOFT_RESET <= 1'h1;
    cyc(8);
    SOFT_RESET <= 1'h0;
    cyc(8);
    rdchk(`ALM_IDX_MASK, 32'h3F, "soft mask");
    rdchk(`ALM_IDX_STATUS, 32'h3F, "soft status");
    rdchk(`ALM_IDX_LANE, 32'hFFFF, "soft lane");
    finish_test();
  end
endmodule : alm_top_test
